//--- rtl/tpa_tx_input_align.v
// Two-channel transmit input capture, phase-align buffer and error flag logic.
`timescale 1ns/1ps
`include "tpa_defines.vh"

// ----------------------------------------------------------------
// Phase-align buffer
// ----------------------------------------------------------------
module tpa_sync_fifo #(
  parameter WIDTH = `TPA_CHAR_WIDTH,
  parameter DEPTH = `TPA_FIFO_DEPTH,
  parameter AW    = `TPA_FIFO_AW
) (
  input  wire             clk,
  input  wire             rstN,
  input  wire             flush,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData,
  output wire [AW:0]      level
);
  // DEPTH must be a power of two so the pointers wrap on their own.
  localparam [AW:0] FULL_LEVEL = DEPTH[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      level_q;

  wire push = inValid & inReady;
  wire pop  = outValid & outReady;

  assign inReady  = (level_q != FULL_LEVEL);
  assign outValid = (level_q != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_q];
  assign level    = level_q;

  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  always @(posedge clk)
  begin
    if (!rstN || flush)
    begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      level_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop)
      begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      if (push && !pop)
      begin
        level_q <= level_q + 1'b1;
      end
      else if (pop && !push)
      begin
        level_q <= level_q - 1'b1;
      end
    end
  end
endmodule // tpa_sync_fifo

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module tpa_tx_input_align (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [9:0]  chanAParallelCharIn,
  input  wire [9:0]  chanBParallelCharIn,
  input  wire        chanAHostTransmitClock,
  input  wire        chanBHostTransmitClock,
  input  wire        chanARefClock,
  input  wire        chanBRefClock,
  output wire        chanAErrorFlag,
  output wire        chanBErrorFlag,
  output wire [9:0]  chanASerialChar,
  output wire [9:0]  chanBSerialChar,
  output wire        chanASerialValid,
  output wire        chanBSerialValid
);
  localparam integer REF_LOSS_CYCLES = `TPA_REF_LOSS_CYCLES;
  localparam [5:0]   REF_LOSS_LIMIT  = REF_LOSS_CYCLES[5:0];

  reg  [15:0] ctrl_q;
  reg  [1:0]  recenter_q;
  wire [15:0] status;
  wire [19:0] charIn   = {chanBParallelCharIn, chanAParallelCharIn};
  wire [1:0]  hostClk  = {chanBHostTransmitClock, chanAHostTransmitClock};
  wire [1:0]  refClk   = {chanBRefClock, chanARefClock};
  wire [1:0]  errFlag;
  wire [19:0] serChar;
  wire [1:0]  serValid;

  assign chanAErrorFlag   = errFlag[0];
  assign chanBErrorFlag   = errFlag[1];
  assign chanASerialChar  = serChar[9:0];
  assign chanBSerialChar  = serChar[19:10];
  assign chanASerialValid = serValid[0];
  assign chanBSerialValid = serValid[1];

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Ack comes one cycle after the request; the write lands on the ack edge.
  wire busWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
      ctrl_q     <= {`TPA_CH_CTRL_RESET, `TPA_CH_CTRL_RESET};
      recenter_q <= 2'h0;
    end
    else
    begin
      wb_ack_o   <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      recenter_q <= 2'h0;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        if (wb_adr_i == `TPA_CTRL_ADDR)
        begin
          wb_dat_o <= {16'h0000, ctrl_q};
        end
        else if (wb_adr_i == `TPA_STATUS_ADDR)
        begin
          wb_dat_o <= {16'h0000, status};
        end
        else
        begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
      if (busWrite && (wb_adr_i == `TPA_CTRL_ADDR))
      begin
        if (wb_sel_i[0])
        begin
          ctrl_q[7:0] <= wb_dat_i[7:0];
          recenter_q[0] <= ~wb_dat_i[`TPA_RECENTER_BIT];
        end
        if (wb_sel_i[1])
        begin
          ctrl_q[15:8] <= wb_dat_i[15:8];
          recenter_q[1] <= ~wb_dat_i[`TPA_CH_STRIDE + `TPA_RECENTER_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-channel datapath
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : gCh
      wire [7:0] cfg      = ctrl_q[c*8 +: 8];
      wire       capSel   = cfg[`TPA_CKSEL_BIT];
      wire       halfRate = cfg[`TPA_HALFRATE_BIT];
      wire       bistOn   = ~cfg[`TPA_SELFTEST_BIT];
      wire       pllDown  = ~cfg[`TPA_OE1_BIT] & ~cfg[`TPA_OE2_BIT];

      reg  [2:0] hclkS_q;
      reg  [2:0] rclkS_q;
      reg  [9:0] dS1_q;
      reg  [9:0] dS2_q;
      reg  [9:0] dS3_q;
      reg  [5:0] missCnt_q;
      reg        centering_q;
      reg        fault_q;
      reg  [8:0] bistCnt_q;
      reg        bistPulse_q;
      reg        errTick_q;
      reg        errOut_q;
      reg  [9:0] serChar_q;
      reg        serValid_q;

      wire       fifoInReady;
      wire       fifoOutValid;
      wire [9:0] fifoOutData;
      wire [2:0] fifoLevel;

      wire hostRise  = hclkS_q[1] & ~hclkS_q[2];
      wire refRise   = rclkS_q[1] & ~rclkS_q[2];
      wire refFall   = ~rclkS_q[1] & rclkS_q[2];
      wire refAbsent = (missCnt_q == REF_LOSS_LIMIT);
      // One character time of the reference: both edges in half-rate mode.
      wire charTick  = (refRise | (halfRate & refFall)) & ~refAbsent;
      // Data sampled one cycle before the detected edge is the settled value.
      wire capTick   = capSel ? charTick : hostRise;
      wire running   = ~centering_q & ~pllDown;
      wire drain     = charTick & running;
      wire overflow  = capTick & ~fifoInReady;
      wire underflow = drain & ~fifoOutValid;
      wire recenter  = recenter_q[c];

      tpa_sync_fifo #(
        .WIDTH (`TPA_CHAR_WIDTH),
        .DEPTH (`TPA_FIFO_DEPTH),
        .AW    (`TPA_FIFO_AW)
      ) uFifo (
        .clk      (ref_clk),
        .rstN     (rst_n),
        .flush    (recenter),
        .inValid  (capTick),
        .inReady  (fifoInReady),
        .inData   (dS3_q),
        .outValid (fifoOutValid),
        .outReady (drain),
        .outData  (fifoOutData),
        .level    (fifoLevel)
      );

      always @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          hclkS_q     <= 3'h0;
          rclkS_q     <= 3'h0;
          dS1_q       <= 10'h000;
          dS2_q       <= 10'h000;
          dS3_q       <= 10'h000;
          missCnt_q   <= 6'h00;
          centering_q <= 1'b1;
          fault_q     <= 1'b0;
          bistCnt_q   <= 9'h000;
          bistPulse_q <= 1'b0;
          errTick_q   <= 1'b0;
          errOut_q    <= 1'b0;
          serChar_q   <= 10'h000;
          serValid_q  <= 1'b0;
        end
        else
        begin
          hclkS_q <= {hclkS_q[1:0], hostClk[c]};
          rclkS_q <= {rclkS_q[1:0], refClk[c]};
          dS1_q   <= charIn[c*10 +: 10];
          dS2_q   <= dS1_q;
          dS3_q   <= dS2_q;

          // Any reference edge proves the clock alive; silence saturates the count.
          if (refRise || refFall)
          begin
            missCnt_q <= 6'h00;
          end
          else if (!refAbsent)
          begin
            missCnt_q <= missCnt_q + 6'h01;
          end

          if (recenter)
          begin
            centering_q <= 1'b1;
          end
          else if (centering_q && (fifoLevel >= `TPA_FIFO_CENTER))
          begin
            centering_q <= 1'b0;
          end

          // A fault in the same cycle as a re-center write still sets the flag.
          if (overflow || underflow)
          begin
            fault_q <= 1'b1;
          end
          else if (recenter)
          begin
            fault_q <= 1'b0;
          end

          if (charTick)
          begin
            if (bistOn)
            begin
              if (bistCnt_q == `TPA_BIST_LAST)
              begin
                bistCnt_q   <= 9'h000;
                bistPulse_q <= 1'b1;
              end
              else
              begin
                bistCnt_q   <= bistCnt_q + 9'h001;
                bistPulse_q <= 1'b0;
              end
            end
            else
            begin
              bistCnt_q   <= 9'h000;
              bistPulse_q <= 1'b0;
            end
            errTick_q <= bistOn ? bistPulse_q : (fault_q | overflow | underflow);
          end

          // Enable, disable and reference loss act at once, not on a reference edge.
          errOut_q <= errTick_q | pllDown | refAbsent;

          serValid_q <= drain & fifoOutValid;
          if (drain && fifoOutValid)
          begin
            serChar_q <= fifoOutData;
          end
        end
      end

      assign errFlag[c]           = errOut_q;
      assign serChar[c*10 +: 10]  = serChar_q;
      assign serValid[c]          = serValid_q;
      assign status[c*8 +: 8]     = {2'h0, pllDown, ~fifoInReady, ~fifoOutValid,
                                     refAbsent, fault_q, errOut_q};
    end
  endgenerate
endmodule // tpa_tx_input_align

//--- rtl/tpa_defines.vh
// Constants for the two-channel transmit input phase-align stage.
`ifndef TPA_DEFINES_VH
`define TPA_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TPA_CTRL_ADDR      4'h0
`define TPA_STATUS_ADDR    4'h4

// ----------------------------------------------------------------
// Control field positions inside one channel byte (A = 7:0, B = 15:8)
// ----------------------------------------------------------------
`define TPA_CH_STRIDE      8
`define TPA_CKSEL_BIT      0
`define TPA_RECENTER_BIT   1
`define TPA_SELFTEST_BIT   2
`define TPA_OE1_BIT        3
`define TPA_OE2_BIT        4
`define TPA_HALFRATE_BIT   5
`define TPA_CH_CTRL_RESET  8'h1E

// ----------------------------------------------------------------
// Status field positions inside one channel byte
// ----------------------------------------------------------------
`define TPA_ST_ERROR_BIT   0
`define TPA_ST_FAULT_BIT   1
`define TPA_ST_NOREF_BIT   2
`define TPA_ST_EMPTY_BIT   3
`define TPA_ST_FULL_BIT    4
`define TPA_ST_PLLDN_BIT   5

// ----------------------------------------------------------------
// Widths, depths and timing
// ----------------------------------------------------------------
`define TPA_CHAR_WIDTH     10
`define TPA_FIFO_DEPTH     4
`define TPA_FIFO_AW        2
`define TPA_FIFO_CENTER    3'h2
`define TPA_BIST_LAST      9'h1FE
`define TPA_CLK_PERIOD_NS  100
`define TPA_REF_LOSS_NS    3200
`define TPA_REF_LOSS_CYCLES ((`TPA_REF_LOSS_NS + `TPA_CLK_PERIOD_NS - 1) / `TPA_CLK_PERIOD_NS)

`endif

//--- tb/tpa_host_model.sv
// Behavioural host that drives one channel's characters and capture clock.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host model
// ------------------------------------------------------------
module tpa_host_model (
  input  wire       refClk,
  input  wire       run,
  output reg        hostClock,
  output reg  [9:0] charOut
);
  initial hostClock = 1'b0;
  initial charOut = 10'h000;
  // The host clock is a delayed copy of the reference, so it stays coherent with a fixed phase.
  always @(refClk) hostClock <= #200 (refClk & run);
  // A new character after each falling host edge keeps data stable around the rising edge.
  always @(negedge hostClock) charOut <= charOut + 10'h001;
endmodule // tpa_host_model

//--- tb/tpa_tx_input_align_sva.sv
// Port checker for the transmit input align block.
`timescale 1ns/1ps
module tpa_tx_input_align_sva (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [3:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        chanARefClock,
  input wire        chanBRefClock,
  input wire        chanAErrorFlag,
  input wire        chanBErrorFlag,
  input wire [9:0]  chanASerialChar,
  input wire        chanASerialValid,
  input wire        chanBSerialValid
);
  reg [5:0] aIdle_q;
  reg [5:0] bIdle_q;
  reg       aPrev_q;
  reg       bPrev_q;
  // ------------------------------------------------------------
  // Reference idle counters
  // ------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    aPrev_q <= chanARefClock;
    bPrev_q <= chanBRefClock;
    if (!rst_n || chanARefClock != aPrev_q) aIdle_q <= 6'h00;
    else if (aIdle_q != 6'h3F) aIdle_q <= aIdle_q + 6'h01;
    if (!rst_n || chanBRefClock != bPrev_q) bIdle_q <= 6'h00;
    else if (bIdle_q != 6'h3F) bIdle_q <= bIdle_q + 6'h01;
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  ack_latency_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) != 4'h0 && $past(wb_adr_i) != 4'h4
    |-> wb_dat_o == 32'h0) else $error("unmapped read data");
  reset_quiet_a: assert property (@(posedge ref_clk)
    !rst_n |=> !wb_ack_o && !chanAErrorFlag && !chanBErrorFlag) else $error("reset outputs");
  valid_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    chanASerialValid |=> !chanASerialValid) else $error("valid A held");
  validb_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    chanBSerialValid |=> !chanBSerialValid) else $error("valid B held");
  char_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !chanASerialValid |-> $stable(chanASerialChar)) else $error("char moved");
  refa_loss_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    aIdle_q >= 6'd40 |-> chanAErrorFlag) else $error("flag A low without reference");
  refb_loss_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bIdle_q >= 6'd40 |-> chanBErrorFlag) else $error("flag B low without reference");
endmodule // tpa_tx_input_align_sva

//--- tb/tb_tpa_tx_input_align.sv
// Self-checking bench for the transmit input align block.
`timescale 1ns/1ps
module tb_tpa_tx_input_align;
  reg ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg [3:0] adr = 4'h0;
  reg [31:0] wdat = 32'h0, rdat;
  reg refA = 1'b0, refB = 1'b0, runRefA = 1'b1, runRefB = 1'b1, runHostA = 1'b1, runHostB = 1'b1;
  wire [31:0] datO;
  wire ack, hostClkA, hostClkB, flagA, flagB, validA, validB;
  wire [9:0] hostCharA, hostCharB, serA, serB;
  integer failures = 0, samples_checked = 0, cycles = 0, w, g;
  always #50 ref_clk = ~ref_clk;
  initial #37 forever #400 refA = runRefA ? ~refA : refA;
  initial #81 forever #400 refB = runRefB ? ~refB : refB;
  tpa_host_model hostA (.refClk(refA), .run(runHostA), .hostClock(hostClkA), .charOut(hostCharA));
  tpa_host_model hostB (.refClk(refB), .run(runHostB), .hostClock(hostClkB), .charOut(hostCharB));
  tpa_tx_input_align DUT (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(datO),
    .wb_ack_o(ack), .chanAParallelCharIn(hostCharA), .chanBParallelCharIn(hostCharB),
    .chanAHostTransmitClock(hostClkA), .chanBHostTransmitClock(hostClkB),
    .chanARefClock(refA), .chanBRefClock(refB), .chanAErrorFlag(flagA), .chanBErrorFlag(flagB),
    .chanASerialChar(serA), .chanBSerialChar(serB), .chanASerialValid(validA),
    .chanBSerialValid(validB));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task check(input [31:0] seen, input [31:0] expected);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== expected)
    begin
      failures = failures + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, expected);
    end
  end
  endtask
  task final_report;
  begin
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // One classic Wishbone cycle, held until ack is sampled high.
  task bus(input isWr, input [3:0] a, input [31:0] d);
  begin
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= isWr; adr <= a; wdat <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1) @(posedge ref_clk);
    rdat = datO;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge ref_clk);
  end
  endtask
  task waitCycles(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Writes the re-center latch as 0 and back to 1 for the masked byte, leaving ctrl in place.
  task recenter(input [15:0] ctrl, input [15:0] mask);
  begin
    bus(1'b1, 4'h0, {16'h0, ctrl & ~mask});
    bus(1'b1, 4'h0, {16'h0, ctrl});
    waitCycles(120);
  end
  endtask
  task waitValid(input ch);
  begin
    w = 0;
    @(posedge ref_clk);
    while ((ch ? validB : validA) !== 1'b1 && w < 200)
    begin
      @(posedge ref_clk);
      w = w + 1;
    end
    check(w < 200, 1);
  end
  endtask
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures = failures + 1;
      final_report;
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    waitCycles(12);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 0); check(rdat, 32'h1E1E);
    bus(1'b1, 4'h8, 32'hFFFF); bus(1'b0, 4'h8, 0); check(rdat, 0);
    recenter(16'h1E1E, 16'h0202); check(flagA, 0); check(flagB, 0);
    for (g = 0; g < 2; g = g + 1)
    begin
      waitValid(g);
      rdat = g ? serB : serA;
      repeat (5)
      begin
        waitValid(g);
        check(g ? serB : serA, rdat[9:0] + 10'h001);
        rdat = g ? serB : serA;
      end
    end
    bus(1'b1, 4'h0, 32'h1E06); waitCycles(100);
    check(flagA, 1); check(flagB, 0);
    bus(1'b0, 4'h4, 0); check(rdat, 32'h0000_0033);
    bus(1'b1, 4'h0, 32'h1E1E); waitCycles(150); check(flagA, 1);
    recenter(16'h1E1E, 16'h0002); check(flagA, 0);
    runHostB <= 1'b0; waitCycles(100);
    check(flagB, 1); check(flagA, 0);
    runHostB <= 1'b1; waitCycles(150); check(flagB, 1);
    recenter(16'h1E1E, 16'h0200); check(flagB, 0);
    runRefA <= 1'b0; runRefB <= 1'b0; waitCycles(60); check(flagA, 1); check(flagB, 1);
    runRefA <= 1'b1; runRefB <= 1'b1; waitCycles(40);
    recenter(16'h1E1E, 16'h0202); check(flagA, 0); check(flagB, 0);
    bus(1'b1, 4'h0, 32'h1E1F); runHostA <= 1'b0;
    recenter(16'h1E1F, 16'h0002); check(flagA, 0);
    waitValid(0); check(serA, hostCharA);
    bus(1'b1, 4'h0, 32'h1E3F); recenter(16'h1E3F, 16'h0002);
    waitValid(0); waitValid(0); check(w, 3); check(flagA, 0);
    bus(1'b1, 4'h0, 32'h1E1E); runHostA <= 1'b1; waitCycles(40);
    recenter(16'h1E1E, 16'h0002);
    bus(1'b1, 4'h0, 32'h1E1A);
    g = 0;
    while (flagA !== 1'b1 && g < 6000) begin @(posedge ref_clk); g = g + 1; end
    w = 0;
    while (flagA === 1'b1 && w < 20) begin @(posedge ref_clk); w = w + 1; end
    check(w, 8);
    g = 0;
    while (flagA !== 1'b1 && g < 5000) begin @(posedge ref_clk); g = g + 1; end
    check(w + g, 4088);
    bus(1'b1, 4'h0, 32'h1E1E);
    final_report;
  end
endmodule // tb_tpa_tx_input_align
bind tpa_tx_input_align tpa_tx_input_align_sva chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chanARefClock(chanARefClock),
  .chanBRefClock(chanBRefClock), .chanAErrorFlag(chanAErrorFlag), .chanBErrorFlag(chanBErrorFlag),
  .chanASerialChar(chanASerialChar), .chanASerialValid(chanASerialValid),
  .chanBSerialValid(chanBSerialValid));
